// ==== hw/fbc_pkg.sv ====
// Constants, carrier types and helpers of the FIFO transfer allowance tracker
package fbc_pkg;

  // Data FIFO geometry
  localparam int FIFO_AW    = 4;
  localparam int FIFO_DEPTH = 1 << FIFO_AW;
  localparam int PTR_W      = FIFO_AW + 1;
  localparam int DATA_W     = 8;

  // Status register layout
  localparam int                CNT_LSB        = 8;
  localparam int                CNT_MSB        = 23;
  localparam int                CNT_W          = CNT_MSB - CNT_LSB + 1;
  localparam logic [1:0]        STS_IDX_FLAGS  = 2'h0;
  localparam logic [1:0]        STS_IDX_CNT_LO = 2'h1;
  localparam logic [1:0]        STS_IDX_CNT_HI = 2'h2;
  localparam logic [DATA_W-1:0] RESEND_MASK    = 8'h02;
  localparam logic [DATA_W-1:0] FLAGS_RESET    = 8'h00;

  // Fixed allowance advertised in fixed mode
  localparam logic [CNT_W-1:0]  FIXED_ALLOWANCE = 16'h0010;
  localparam logic [CNT_W-1:0]  CNT_ZERO        = 16'h0000;
  localparam logic [PTR_W-1:0]  PTR_ZERO        = 5'h00;
  localparam logic [PTR_W-1:0]  PTR_DEPTH       = 5'h10;

  // One register cycle from the host
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [1:0]        idx;
    logic [DATA_W-1:0] wdata;
  } fbc_csr_req_t;

  // One data FIFO cycle from the host
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] wdata;
  } fbc_dat_req_t;

  function automatic logic [PTR_W-1:0] fbc_gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : fbc_gray2bin

  function automatic logic [PTR_W-1:0] fbc_bin2gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : fbc_bin2gray

endpackage : fbc_pkg

// ==== hw/fbc_sync2.sv ====
// Two-flop level synchroniser
module fbc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk) begin
    meta_q <= i_d;
    o_q    <= meta_q;
  end
endmodule : fbc_sync2

// ==== hw/fbc_afifo.sv ====
// Dual-clock byte FIFO with gray pointers and a rewindable read side
module fbc_afifo
  import fbc_pkg::*;
(
  // Write side
  input  wire logic              i_wclk,
  input  wire logic              i_wrst_n,
  input  wire logic              i_push,
  input  wire logic [DATA_W-1:0] i_wdata,
  output logic      [PTR_W-1:0]  o_space,
  // Read side
  input  wire logic              i_rclk,
  input  wire logic              i_rrst_n,
  input  wire logic              i_pop,
  input  wire logic              i_rewind,
  input  wire logic              i_commit,
  output logic      [PTR_W-1:0]  o_avail,
  output logic      [DATA_W-1:0] o_rdata
);
  logic [DATA_W-1:0] mem [FIFO_DEPTH];
  logic [PTR_W-1:0]  wptr_q, wgray_q, rptr_q, rptr_d, rbase_q, rbase_gray_q;
  logic [PTR_W-1:0]  rbase_gray_w, wgray_r;

  fbc_sync2 #(.W(PTR_W)) u_rb_sync (.i_clk(i_wclk), .i_d(rbase_gray_q), .o_q(rbase_gray_w));
  fbc_sync2 #(.W(PTR_W)) u_wp_sync (.i_clk(i_rclk), .i_d(wgray_q), .o_q(wgray_r));

  ////////////////////////////////////////////////////////////////////////////
  // Write side: space is counted against the released base, not the reader
  assign o_space = PTR_DEPTH - (wptr_q - fbc_gray2bin(rbase_gray_w));

  always_ff @(posedge i_wclk) begin
    if (i_push && o_space != PTR_ZERO) begin
      mem[wptr_q[FIFO_AW-1:0]] <= i_wdata;
    end
  end

  always_ff @(posedge i_wclk) begin
    if (!i_wrst_n) begin
      wptr_q  <= PTR_ZERO;
      wgray_q <= PTR_ZERO;
    end else if (i_push && o_space != PTR_ZERO) begin
      wptr_q  <= wptr_q + 5'h01;
      wgray_q <= fbc_bin2gray(wptr_q + 5'h01);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read side: bytes stay held until committed, so a rewind can replay them
  assign o_avail = fbc_gray2bin(wgray_r) - rptr_q;
  assign o_rdata = mem[rptr_q[FIFO_AW-1:0]];

  always_comb begin
    rptr_d = rptr_q;
    if (i_rewind) begin
      rptr_d = rbase_q;
    end else if (i_pop && o_avail != PTR_ZERO) begin
      rptr_d = rptr_q + 5'h01;
    end
  end

  always_ff @(posedge i_rclk) begin
    if (!i_rrst_n) begin
      rptr_q       <= PTR_ZERO;
      rbase_q      <= PTR_ZERO;
      rbase_gray_q <= PTR_ZERO;
    end else begin
      rptr_q <= rptr_d;
      if (i_commit) begin
        rbase_q      <= rptr_d;
        rbase_gray_q <= fbc_bin2gray(rptr_d);
      end
    end
  end
endmodule : fbc_afifo

// ==== hw/fbc_tracker.sv ====
// FIFO transfer allowance tracker: host link side and command processor side
//
// Overview of operation
// - Writing one to resend_request replays the current response; it always reads zero.
// - Dynamic mode, command send: allowance zero while the FIFO cannot take a byte.
// - Dynamic mode, command send: allowance equals bytes writable without waiting.
// - Dynamic mode: each host command byte entering the FIFO decrements the allowance.
// - Dynamic mode: each command byte the processor removes increments the allowance.
// - Dynamic mode, response read: allowance zero while no byte can be returned.
// - Dynamic mode, response read: allowance equals bytes readable without waiting.
// - Dynamic mode: each response byte the host reads decrements the allowance.
// - Dynamic mode: each response byte the processor places increments the allowance.
// - Fixed mode, command send: allowance zero while the FIFO cannot take a burst.
// - Fixed mode, command send: allowance shows the fixed maximum when ready.
// - Fixed mode: first command byte of a burst drops allowance to zero until complete.
// - Fixed mode: after the full command burst the fixed value is shown again.
// - Fixed mode: advertised value never changes between module initialisations.
// - Fixed mode, response read: fixed maximum when data ready, else zero.
// - Fixed mode: first response byte read drops allowance to zero until complete.
// - Fixed mode: after the full response burst the fixed value is shown again.
// - Allowance sits read-only in command_status bits 23 down to 8.
// - Both allowance bytes read in separate cycles give one consistent value when the lower byte is read first.
module fbc_tracker
  import fbc_pkg::*;
(
  // System clock and module initialisation
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_n,
  // Host link clock and cycles
  input  wire logic                  i_lnk_clk,
  input  wire fbc_pkg::fbc_csr_req_t i_csr_req,
  input  wire fbc_pkg::fbc_dat_req_t i_dat_req,
  output logic      [DATA_W-1:0]     o_csr_rdata,
  output logic      [DATA_W-1:0]     o_dat_rdata,
  // Capability strap
  input  wire logic                  i_fixed_allowance_flag,
  // Command processor
  input  wire logic                  i_phase_rsp,
  input  wire logic                  i_rsp_complete,
  input  wire logic                  i_cmd_pop,
  output logic                       o_cmd_valid,
  output logic      [DATA_W-1:0]     o_cmd_data,
  output logic                       o_cmd_avail,
  input  wire logic                  i_rsp_push,
  input  wire logic [DATA_W-1:0]     i_rsp_data,
  output logic                       o_rsp_space,
  output logic                       o_resend_req
);
  logic              lnk_rst_n;
  logic              phase_rsp_l, rsp_done_l, fixed_strap_l;
  logic              phase_prev_q, fixed_mode_q, strap_taken_q;
  logic [PTR_W-1:0]  cmd_space_l, rsp_avail_l, cmd_avail_s, rsp_space_s;
  logic [DATA_W-1:0] cmd_head_s, rsp_head_l;
  logic              host_wr_ok, host_rd_ok, host_burst_step;
  logic              resend_wr, commit_rsp;
  logic [CNT_W-1:0]  burst_left_q, dyn_cnt, allowance;
  logic              fixed_ready;
  logic [DATA_W-1:0] hi_latch_q;
  logic              hi_valid_q;
  logic              resend_tgl_q, resend_tgl_s, resend_seen_q;

  ////////////////////////////////////////////////////////////////////////////
  // Crossings into the link domain
  fbc_sync2 #(.W(1)) u_rst_sync (.i_clk(i_lnk_clk), .i_d(i_rst_n), .o_q(lnk_rst_n));
  fbc_sync2 #(.W(3)) u_lvl_sync (
    .i_clk (i_lnk_clk),
    .i_d   ({i_phase_rsp, i_rsp_complete, i_fixed_allowance_flag}),
    .o_q   ({phase_rsp_l, rsp_done_l, fixed_strap_l})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Data FIFOs: command flows link to system, response system to link
  assign host_wr_ok = i_dat_req.wr && !phase_rsp_l && cmd_space_l != PTR_ZERO;
  assign host_rd_ok = i_dat_req.rd && phase_rsp_l && rsp_avail_l != PTR_ZERO;
  assign resend_wr  = i_csr_req.wr && i_csr_req.idx == STS_IDX_FLAGS
                      && i_csr_req.wdata == RESEND_MASK;
  assign commit_rsp = phase_prev_q && !phase_rsp_l;

  fbc_afifo u_cmd_fifo (
    .i_wclk   (i_lnk_clk),
    .i_wrst_n (lnk_rst_n),
    .i_push   (host_wr_ok),
    .i_wdata  (i_dat_req.wdata),
    .o_space  (cmd_space_l),
    .i_rclk   (i_sys_clk),
    .i_rrst_n (i_rst_n),
    .i_pop    (i_cmd_pop),
    .i_rewind (1'b0),
    .i_commit (1'b1),
    .o_avail  (cmd_avail_s),
    .o_rdata  (cmd_head_s)
  );

  fbc_afifo u_rsp_fifo (
    .i_wclk   (i_sys_clk),
    .i_wrst_n (i_rst_n),
    .i_push   (i_rsp_push),
    .i_wdata  (i_rsp_data),
    .o_space  (rsp_space_s),
    .i_rclk   (i_lnk_clk),
    .i_rrst_n (lnk_rst_n),
    .i_pop    (host_rd_ok),
    .i_rewind (resend_wr),
    .i_commit (commit_rsp),
    .o_avail  (rsp_avail_l),
    .o_rdata  (rsp_head_l)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Phase tracking and fixed-mode strap capture after reset release
  always_ff @(posedge i_lnk_clk) begin
    if (!lnk_rst_n) begin
      phase_prev_q  <= 1'b0;
      strap_taken_q <= 1'b0;
      fixed_mode_q  <= 1'b0;
    end else begin
      phase_prev_q <= phase_rsp_l;
      if (!strap_taken_q) begin
        strap_taken_q <= 1'b1;
        fixed_mode_q  <= fixed_strap_l;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Allowance computation
  // Dynamic count follows link-side pointers: host moves show at once, processor moves only after the two-flop synchroniser
  assign dyn_cnt = phase_rsp_l ? CNT_W'(rsp_avail_l)
                               : CNT_W'(cmd_space_l);

  // A short final response burst is released once the processor marks it done
  assign fixed_ready = phase_rsp_l
      ? (CNT_W'(rsp_avail_l) >= FIXED_ALLOWANCE
         || (rsp_done_l && rsp_avail_l != PTR_ZERO))
      : (CNT_W'(cmd_space_l) >= FIXED_ALLOWANCE);

  assign allowance = !fixed_mode_q ? dyn_cnt
                   : (burst_left_q == CNT_ZERO && fixed_ready) ? FIXED_ALLOWANCE
                   : CNT_ZERO;

  assign host_burst_step = host_wr_ok || host_rd_ok;

  always_ff @(posedge i_lnk_clk) begin
    if (!lnk_rst_n) begin
      burst_left_q <= CNT_ZERO;
    end else if (resend_wr || phase_rsp_l != phase_prev_q) begin
      burst_left_q <= CNT_ZERO;
    end else if (fixed_mode_q && host_burst_step) begin
      if (burst_left_q == CNT_ZERO) begin
        burst_left_q <= FIXED_ALLOWANCE - 16'h0001;
      end else begin
        burst_left_q <= burst_left_q - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads: upper byte latched on the lower byte read
  always_ff @(posedge i_lnk_clk) begin
    if (!lnk_rst_n) begin
      hi_latch_q <= FLAGS_RESET;
      hi_valid_q <= 1'b0;
    end else if (i_csr_req.rd && i_csr_req.idx == STS_IDX_CNT_LO) begin
      hi_latch_q <= allowance[CNT_W-1:DATA_W];
      hi_valid_q <= 1'b1;
    end else if (i_dat_req.wr || i_dat_req.rd || resend_wr
                 || (i_csr_req.rd && i_csr_req.idx == STS_IDX_CNT_HI)) begin
      hi_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge i_lnk_clk) begin
    if (!lnk_rst_n) begin
      o_csr_rdata <= FLAGS_RESET;
    end else if (i_csr_req.rd) begin
      case (i_csr_req.idx)
        STS_IDX_CNT_LO: o_csr_rdata <= allowance[DATA_W-1:0];
        STS_IDX_CNT_HI: o_csr_rdata <= hi_valid_q ? hi_latch_q
                                                  : allowance[CNT_W-1:DATA_W];
        default:        o_csr_rdata <= FLAGS_RESET;
      endcase
    end
  end

  always_ff @(posedge i_lnk_clk) begin
    if (!lnk_rst_n) begin
      o_dat_rdata <= FLAGS_RESET;
    end else if (host_rd_ok) begin
      o_dat_rdata <= rsp_head_l;
    end
  end

  always_ff @(posedge i_lnk_clk) begin
    if (!lnk_rst_n) begin
      resend_tgl_q <= 1'b0;
    end else if (resend_wr) begin
      resend_tgl_q <= ~resend_tgl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command processor side
  fbc_sync2 #(.W(1)) u_tgl_sync (.i_clk(i_sys_clk), .i_d(resend_tgl_q), .o_q(resend_tgl_s));

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      resend_seen_q <= 1'b0;
      o_resend_req  <= 1'b0;
    end else begin
      resend_seen_q <= resend_tgl_s;
      o_resend_req  <= resend_tgl_s ^ resend_seen_q;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_cmd_valid <= 1'b0;
      o_cmd_data  <= FLAGS_RESET;
      o_cmd_avail <= 1'b0;
      o_rsp_space <= 1'b0;
    end else begin
      o_cmd_valid <= i_cmd_pop && cmd_avail_s != PTR_ZERO;
      if (i_cmd_pop && cmd_avail_s != PTR_ZERO) begin
        o_cmd_data <= cmd_head_s;
      end
      o_cmd_avail <= cmd_avail_s > 5'h01 || (cmd_avail_s == 5'h01 && !i_cmd_pop);
      o_rsp_space <= rsp_space_s > 5'h01 || (rsp_space_s == 5'h01 && !i_rsp_push);
    end
  end
endmodule : fbc_tracker

// ==== test/fbc_tracker_chk.sv ====
// Port assertions of the transfer allowance tracker
module fbc_tracker_chk
  import fbc_pkg::*;
(
  // Clocks and reset
  input wire logic                  i_sys_clk,
  input wire logic                  i_rst_n,
  input wire logic                  i_lnk_clk,
  // Host link
  input wire fbc_pkg::fbc_csr_req_t i_csr_req,
  input wire fbc_pkg::fbc_dat_req_t i_dat_req,
  input wire logic [DATA_W-1:0]     o_csr_rdata,
  input wire logic [DATA_W-1:0]     o_dat_rdata,
  // Strap and processor
  input wire logic                  i_fixed_allowance_flag,
  input wire logic                  i_cmd_pop,
  input wire logic                  o_cmd_valid,
  input wire logic                  o_resend_req
);
  ////////////////////////////////////////////////////////////////////////////////
  flags_read_zero_a: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_n)
    i_csr_req.rd && i_csr_req.idx == STS_IDX_FLAGS |=> o_csr_rdata == 8'h00)
    else $error("status flag byte read nonzero");
  resend_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(i_csr_req.wr && i_csr_req.idx == STS_IDX_FLAGS && i_csr_req.wdata == RESEND_MASK)
    |-> ##[1:12] o_resend_req) else $error("resend request not passed on");
  resend_single_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_resend_req |=> !o_resend_req) else $error("resend pulse longer than one cycle");
  high_byte_zero_a: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_n)
    i_csr_req.rd && i_csr_req.idx == STS_IDX_CNT_HI |=> o_csr_rdata == 8'h00)
    else $error("allowance high byte nonzero");
  low_byte_bound_a: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_n)
    i_csr_req.rd && i_csr_req.idx == STS_IDX_CNT_LO |=> o_csr_rdata <= 8'h10)
    else $error("allowance above fifo depth");
  fixed_values_a: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_n)
    i_csr_req.rd && i_csr_req.idx == STS_IDX_CNT_LO && i_fixed_allowance_flag
    |=> o_csr_rdata inside {8'h00, 8'h10}) else $error("fixed allowance has odd value");
  csr_hold_a: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_n)
    !i_csr_req.rd |=> $stable(o_csr_rdata)) else $error("register data moved without read");
  dat_hold_a: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_n)
    !i_dat_req.rd |=> $stable(o_dat_rdata)) else $error("response byte moved without read");
  cmd_cause_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cmd_valid |-> $past(i_cmd_pop)) else $error("command byte without pop");
  resend_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) o_resend_req);
  cmd_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) o_cmd_valid);
  fixed_c: cover property (@(posedge i_lnk_clk) disable iff (!i_rst_n)
    i_fixed_allowance_flag && i_csr_req.rd ##1 o_csr_rdata == 8'h10);
endmodule : fbc_tracker_chk

bind fbc_tracker fbc_tracker_chk i_fbc_tracker_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_lnk_clk(i_lnk_clk),
  .i_csr_req(i_csr_req), .i_dat_req(i_dat_req), .o_csr_rdata(o_csr_rdata),
  .o_dat_rdata(o_dat_rdata), .i_fixed_allowance_flag(i_fixed_allowance_flag),
  .i_cmd_pop(i_cmd_pop), .o_cmd_valid(o_cmd_valid), .o_resend_req(o_resend_req)
);

// ==== test/fbc_host_model.sv ====
// Host link master model issuing register and data FIFO cycles
module fbc_host_model
  import fbc_pkg::*;
(
  // Link clock and answers
  input  wire logic              i_lnk_clk,
  input  wire logic [DATA_W-1:0] i_csr_rdata,
  input  wire logic [DATA_W-1:0] i_dat_rdata,
  // Requests
  output fbc_pkg::fbc_csr_req_t  o_csr_req,
  output fbc_pkg::fbc_dat_req_t  o_dat_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_csr_req = '0;
    o_dat_req = '0;
  end
  // One cycle request; released fields show inverted data
  task automatic cyc(input fbc_csr_req_t c, input fbc_dat_req_t d);
    @(negedge i_lnk_clk);
    o_csr_req = c;
    o_dat_req = d;
    @(negedge i_lnk_clk);
    o_csr_req = '{1'b0, 1'b0, ~c.idx, ~c.wdata};
    o_dat_req = '{1'b0, 1'b0, ~d.wdata};
    @(posedge i_lnk_clk);
    #1;
  endtask : cyc
  task automatic csr_rd(input logic [1:0] idx, output logic [7:0] v);
    cyc('{1'b0, 1'b1, idx, 8'h00}, '0);
    v = i_csr_rdata;
  endtask : csr_rd
  task automatic csr_wr(input logic [1:0] idx, input logic [7:0] v);
    cyc('{1'b1, 1'b0, idx, v}, '0);
  endtask : csr_wr
  task automatic dat_wr(input logic [7:0] v);
    cyc('0, '{1'b1, 1'b0, v});
  endtask : dat_wr
  task automatic dat_rd(output logic [7:0] v);
    cyc('0, '{1'b0, 1'b1, 8'h00});
    v = i_dat_rdata;
  endtask : dat_rd
endmodule : fbc_host_model

// ==== test/fbc_tracker_tb.sv ====
// Self-checking bench of the transfer allowance tracker
module fbc_tracker_tb;
  import fbc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic         sys_clk = 1'b0, lnk_clk = 1'b0, rst_n = 1'b0, flag = 1'b0;
  logic         phase = 1'b0, cmpl = 1'b0, pop = 1'b0, push = 1'b0;
  logic [7:0]   pdata = 8'h00, csr_rd, dat_rd, cmd_data, b;
  logic         cmd_valid, cmd_avail, rsp_space, resend;
  fbc_csr_req_t csr;
  fbc_dat_req_t dat;
  int           n_mismatch = 0, n_tests = 0, n_resend = 0;
  logic [31:0]  seed = 32'h71cb4b4f;
  logic [7:0]   q[$], r[$];
  always #5 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever #15 lnk_clk = ~lnk_clk;
  end
  always @(negedge sys_clk) if (resend === 1'b1) n_resend++;
  fbc_host_model i_fbc_host_model (.i_lnk_clk(lnk_clk), .i_csr_rdata(csr_rd),
    .i_dat_rdata(dat_rd), .o_csr_req(csr), .o_dat_req(dat));
  fbc_tracker i_fbc_tracker (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_lnk_clk(lnk_clk),
    .i_csr_req(csr), .i_dat_req(dat), .o_csr_rdata(csr_rd), .o_dat_rdata(dat_rd),
    .i_fixed_allowance_flag(flag), .i_phase_rsp(phase), .i_rsp_complete(cmpl),
    .i_cmd_pop(pop), .o_cmd_valid(cmd_valid), .o_cmd_data(cmd_data),
    .o_cmd_avail(cmd_avail), .i_rsp_push(push), .i_rsp_data(pdata),
    .o_rsp_space(rsp_space), .o_resend_req(resend));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [15:0] exp_dyn(input logic rsp, input int held);
    return rsp ? 16'(held) : 16'(FIFO_DEPTH - held);
  endfunction : exp_dyn
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic expect_cnt(input logic [15:0] exp);
    logic [7:0] lo, hi;
    for (int i = 0; i < 40; i++) begin
      i_fbc_host_model.csr_rd(STS_IDX_CNT_LO, lo);
      if (lo === exp[7:0]) break;
    end
    i_fbc_host_model.csr_rd(STS_IDX_CNT_HI, hi);
    check("allowance", {hi, lo}, exp);
  endtask : expect_cnt
  task automatic wr_bytes(input int n);
    repeat (n) begin
      seed = xs(seed);
      q.push_back(seed[7:0]);
      i_fbc_host_model.dat_wr(seed[7:0]);
    end
  endtask : wr_bytes
  task automatic pop_bytes(input int n);
    repeat (n) begin
      for (int i = 0; i < 20 && cmd_avail !== 1'b1; i++) @(negedge sys_clk);
      pop = 1'b1;
      @(negedge sys_clk);
      pop = 1'b0;
      for (int i = 0; i < 3 && cmd_valid !== 1'b1; i++) @(negedge sys_clk);
      check("command byte", cmd_data, q.pop_front());
      @(negedge sys_clk);
    end
  endtask : pop_bytes
  task automatic push_bytes(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      seed = xs(seed);
      push = 1'b1;
      pdata = seed[7:0];
      q.push_back(seed[7:0]);
    end
    @(negedge sys_clk);
    push = 1'b0;
  endtask : push_bytes
  task automatic rd_bytes(input int n);
    repeat (n) begin
      i_fbc_host_model.dat_rd(b);
      check("response byte", b, q.pop_front());
    end
  endtask : rd_bytes
  task automatic do_resend();
    i_fbc_host_model.csr_wr(STS_IDX_FLAGS, RESEND_MASK);
    i_fbc_host_model.csr_rd(STS_IDX_FLAGS, b);
    check("flag byte", b, 16'h0000);
    q = r;
  endtask : do_resend
  task automatic run_reset(input logic f);
    @(negedge sys_clk);
    rst_n = 1'b0;
    flag = f;
    phase = 1'b0;
    cmpl = 1'b0;
    q.delete();
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (20) @(negedge sys_clk);
  endtask : run_reset
  task automatic go_rsp();
    @(negedge sys_clk);
    phase = 1'b1;
  endtask : go_rsp
  initial begin
    #900000;
    n_mismatch++;
    summarize();
  end
  initial begin
    run_reset(1'b0);
    expect_cnt(exp_dyn(0, 0));
    wr_bytes(5);
    expect_cnt(exp_dyn(0, 5));
    pop_bytes(2);
    expect_cnt(exp_dyn(0, 3));
    wr_bytes(13);
    expect_cnt(exp_dyn(0, 16));
    i_fbc_host_model.dat_wr(8'h5a);
    pop_bytes(16);
    go_rsp();
    expect_cnt(exp_dyn(1, 0));
    push_bytes(3);
    r = q;
    expect_cnt(exp_dyn(1, 3));
    rd_bytes(1);
    expect_cnt(exp_dyn(1, 2));
    do_resend();
    expect_cnt(exp_dyn(1, 3));
    rd_bytes(3);
    check("resend pulses", 16'(n_resend), 16'h0001);
    $display("dynamic test done");
    run_reset(1'b1);
    expect_cnt(FIXED_ALLOWANCE);
    wr_bytes(1);
    expect_cnt(CNT_ZERO);
    wr_bytes(15);
    expect_cnt(CNT_ZERO);
    pop_bytes(16);
    expect_cnt(FIXED_ALLOWANCE);
    go_rsp();
    expect_cnt(CNT_ZERO);
    push_bytes(16);
    cmpl = 1'b1;
    r = q;
    expect_cnt(FIXED_ALLOWANCE);
    rd_bytes(1);
    expect_cnt(CNT_ZERO);
    rd_bytes(15);
    do_resend();
    expect_cnt(FIXED_ALLOWANCE);
    rd_bytes(16);
    $display("fixed test done");
    summarize();
  end
endmodule : fbc_tracker_tb
